/* File: rtl/hbridge_map.vh */
// constants for the dual h-bridge pwm current regulator
`ifndef HBRIDGE_MAP_VH
`define HBRIDGE_MAP_VH

// clocking
`define CORE_CLK_HZ 10000000
`define CORE_CLK_MHZ 10
`define OSC_HZ 4000000
`define OSC_MHZ 4

// pwm frequencies in hz
`define PWM_BASE_HZ 22800
`define PWM_DOUBLE_HZ 45600

// jitter span in oscillator ticks, centred on the nominal period
`define JITTER_SPAN 8
`define JITTER_HALF 4
`define LFSR_SEED 8'hA5

// interlock dead time in ns
`define DEADTIME_NS 500

// nominal slopes in v/us for codes 00, 01, 10, 11
`define SLOPE_00_VUS 150
`define SLOPE_01_VUS 100
`define SLOPE_10_VUS 50
`define SLOPE_11_VUS 25

// low-side on-resistance switch level on the requested coil level
`define RDSON_LEVEL_THR 7'h40

// register byte offsets
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_FAULT_CLR 4'h8

// control register fields
`define CTRL_ENABLE 0
`define CTRL_DOUBLE 1
`define CTRL_JITTER 2
`define CTRL_SLOPE_LO 3
`define CTRL_SLOPE_HI 4
`define CTRL_RESET 8'h00

// coil regulation states
`define ST_OFF 2'h0
`define ST_FWD 2'h1
`define ST_SLOW 2'h2
`define ST_FAST 2'h3

`endif

/* File: rtl/half_bridge_gate.v */
// gate sequencing for one half-bridge with interlock and protection
`timescale 1ns/1ps
module half_bridge_gate #(
	parameter DT_CYCLES = 5
) (
	// clock and reset
	input wire core_clk,
	input wire srst,
	// control
	input wire enable,
	input wire hs_req,
	input wire ls_req,
	input wire fault_clear,
	// analog sense
	input wire hs_rev,
	input wire ls_rev,
	input wire hs_oc,
	input wire ls_oc,
	input wire hs_desat,
	input wire ls_desat,
	// gate drive
	output wire hs_on,
	output wire ls_on,
	output wire hs_limit,
	output wire ls_limit,
	output wire hs_fault,
	output wire ls_fault
);

	reg hs_on_ff;
	reg ls_on_ff;
	reg hs_limit_ff;
	reg ls_limit_ff;
	reg hs_fault_ff;
	reg ls_fault_ff;
	reg [7:0] dt_cnt_ff;
	wire want_h;
	wire want_l;
	localparam integer DT_I = DT_CYCLES;
	localparam [7:0] DT_LOAD = DT_I[7:0];

	// reverse current turns a switch on like a driven request
	assign want_h = (hs_req | hs_rev) & ~hs_fault_ff;
	assign want_l = (ls_req | (ls_rev & ~hs_req)) & ~want_h & ~ls_fault_ff;

	// break before make with a dead time between opposite switches
	always @(posedge core_clk) begin
		if (srst || !enable) begin
			hs_on_ff <= 1'b0;
			ls_on_ff <= 1'b0;
			dt_cnt_ff <= 8'h00;
		end else if (hs_on_ff && !want_h) begin
			hs_on_ff <= 1'b0;
			dt_cnt_ff <= DT_LOAD;
		end else if (ls_on_ff && !want_l) begin
			ls_on_ff <= 1'b0;
			dt_cnt_ff <= DT_LOAD;
		end else if (dt_cnt_ff != 8'h00) begin
			dt_cnt_ff <= dt_cnt_ff - 8'h01;
		end else if (want_h && !ls_on_ff) begin
			hs_on_ff <= 1'b1;
		end else if (want_l && !hs_on_ff) begin
			ls_on_ff <= 1'b1;
		end
	end

	// current limit stage and latched desaturation shutdown, set wins
	always @(posedge core_clk) begin
		if (srst) begin
			hs_limit_ff <= 1'b0;
			ls_limit_ff <= 1'b0;
			hs_fault_ff <= 1'b0;
			ls_fault_ff <= 1'b0;
		end else begin
			hs_limit_ff <= hs_on_ff & ~hs_fault_ff & hs_oc;
			ls_limit_ff <= ls_on_ff & ~ls_fault_ff & ls_oc;
			hs_fault_ff <= (hs_fault_ff & ~fault_clear) | (hs_on_ff & hs_desat);
			ls_fault_ff <= (ls_fault_ff & ~fault_clear) | (ls_on_ff & ls_desat);
		end
	end

	// a tripped switch is dropped in the same cycle
	assign hs_on = hs_on_ff & ~hs_fault_ff;
	assign ls_on = ls_on_ff & ~ls_fault_ff;
	assign hs_limit = hs_limit_ff;
	assign ls_limit = ls_limit_ff;
	assign hs_fault = hs_fault_ff;
	assign ls_fault = ls_fault_ff;

endmodule // half_bridge_gate

/* File: rtl/hbridge_pwm_current_regulator.v */
// dual h-bridge drive with pwm current regulation and register slave
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "hbridge_map.vh"
module hbridge_pwm_current_regulator #(
	parameter NCOIL = 2,
	parameter LVL_W = 7
) (
	// clock and reset
	input wire core_clk,
	input wire srst,
	// avalon-mm slave
	input wire [3:0] address,
	input wire read,
	input wire write,
	input wire [3:0] byteenable,
	input wire [31:0] writedata,
	output wire [31:0] readdata,
	output wire waitrequest,
	// coil current sense and request, one bit or field per coil, current_range_high shared by both coils
	input wire [NCOIL-1:0] coil_above,
	input wire [NCOIL-1:0] coil_negative,
	input wire [NCOIL*LVL_W-1:0] coil_level,
	input wire current_range_high,
	// switch sense, one bit per half-bridge
	input wire [2*NCOIL-1:0] hs_reverse,
	input wire [2*NCOIL-1:0] ls_reverse,
	input wire [2*NCOIL-1:0] hs_overcurrent,
	input wire [2*NCOIL-1:0] ls_overcurrent,
	input wire [2*NCOIL-1:0] hs_desat,
	input wire [2*NCOIL-1:0] ls_desat,
	// gate drive, one bit per half-bridge for gates and limits, shared or per-coil for the other outputs
	output wire [2*NCOIL-1:0] hs_gate,
	output wire [2*NCOIL-1:0] ls_gate,
	output wire [2*NCOIL-1:0] hs_current_limit,
	output wire [2*NCOIL-1:0] ls_current_limit,
	output wire bridge_hiz,
	output wire [1:0] gate_drive_strength,
	output wire [NCOIL-1:0] ls_low_rdson,
	output wire pwm_period_start
);

	////////////////////////////////////////////////////////////////////////
	// timing constants

	localparam integer DT_CYCLES = (`DEADTIME_NS * `CORE_CLK_MHZ + 999) / 1000;
	// integer forms are cut to the counter widths on purpose
	localparam integer PER_BASE_I = `OSC_HZ / `PWM_BASE_HZ;
	localparam integer PER_DOUBLE_I = `OSC_HZ / `PWM_DOUBLE_HZ;
	localparam integer ACC_STEP_I = `OSC_MHZ;
	localparam integer ACC_WRAP_I = `CORE_CLK_MHZ;
	localparam integer JIT_HALF_I = `JITTER_HALF;
	localparam [7:0] PER_BASE = PER_BASE_I[7:0];
	localparam [7:0] PER_DOUBLE = PER_DOUBLE_I[7:0];
	localparam [3:0] ACC_STEP = ACC_STEP_I[3:0];
	localparam [3:0] ACC_WRAP = ACC_WRAP_I[3:0];
	localparam [7:0] JIT_HALF = JIT_HALF_I[7:0];
	localparam [6:0] RDSON_THR = `RDSON_LEVEL_THR;

	////////////////////////////////////////////////////////////////////////
	// register slave

	reg [7:0] ctrl_ff;
	reg ack_ff;
	reg [31:0] rdata_ff;
	reg fault_clear_ff;
	wire req;
	wire [31:0] status;
	wire [2*NCOIL-1:0] hs_fault;
	wire [2*NCOIL-1:0] ls_fault;
	wire [2*NCOIL-1:0] coil_st;
	reg dbl_act_ff;
	reg jit_act_ff;
	reg [1:0] slope_act_ff;

	// either strobe opens a request
	assign req = read | write;
	// one wait cycle, then the request completes
	assign waitrequest = req & ~ack_ff;
	assign readdata = rdata_ff;

	// status word shows faults, coil states and active settings
	assign status = {15'h0000, jit_act_ff, slope_act_ff, dbl_act_ff, ctrl_ff[`CTRL_ENABLE],
		coil_st[3:0], ls_fault, hs_fault};

	// decode, read capture on the first edge, write on the completing edge
	always @(posedge core_clk) begin
		if (srst) begin
			ack_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			ctrl_ff <= `CTRL_RESET;
			fault_clear_ff <= 1'b0;
		end else begin
			ack_ff <= req & ~ack_ff;
			fault_clear_ff <= 1'b0;
			if (read && !ack_ff) begin
				case (address)
				`REG_CTRL: rdata_ff <= {24'h000000, ctrl_ff};
				`REG_STATUS: rdata_ff <= status;
				default: rdata_ff <= 32'h00000000;
				endcase
			end
			if (write && ack_ff && byteenable[0]) begin
				case (address)
				`REG_CTRL: ctrl_ff <= {3'h0, writedata[4:0]};
				`REG_FAULT_CLR: fault_clear_ff <= writedata[0];
				default: ctrl_ff <= ctrl_ff;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pwm clock and period

	reg [3:0] acc_ff;
	reg osc_tick_ff;
	reg [7:0] per_cnt_ff;
	reg [7:0] per_len_ff;
	reg [7:0] lfsr_ff;
	reg start_ff;
	wire [3:0] acc_sum;
	wire per_end;
	wire [7:0] nxt_nom;
	wire [7:0] nxt_len;

	// fractional divider gives a 4 mhz average tick from the core clock
	assign acc_sum = acc_ff + ACC_STEP;
	always @(posedge core_clk) begin
		if (srst) begin
			acc_ff <= 4'h0;
			osc_tick_ff <= 1'b0;
		end else if (acc_sum >= ACC_WRAP) begin
			acc_ff <= acc_sum - ACC_WRAP;
			osc_tick_ff <= 1'b1;
		end else begin
			acc_ff <= acc_sum;
			osc_tick_ff <= 1'b0;
		end
	end

	// period length for the next period from settings sampled now
	assign per_end = osc_tick_ff && (per_cnt_ff >= per_len_ff - 8'h01);
	assign nxt_nom = ctrl_ff[`CTRL_DOUBLE] ? PER_DOUBLE : PER_BASE;
	assign nxt_len = ctrl_ff[`CTRL_JITTER] ?
		(nxt_nom - JIT_HALF + {5'h00, lfsr_ff[2:0]}) : nxt_nom;

	// period counter runs on oscillator ticks only
	always @(posedge core_clk) begin
		if (srst) begin
			per_cnt_ff <= 8'h00;
			per_len_ff <= PER_BASE;
			lfsr_ff <= `LFSR_SEED;
			start_ff <= 1'b0;
			dbl_act_ff <= 1'b0;
			jit_act_ff <= 1'b0;
			slope_act_ff <= 2'h0;
		end else begin
			start_ff <= per_end;
			if (per_end) begin
				per_cnt_ff <= 8'h00;
				per_len_ff <= nxt_len;
				lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
				dbl_act_ff <= ctrl_ff[`CTRL_DOUBLE];
				jit_act_ff <= ctrl_ff[`CTRL_JITTER];
				slope_act_ff <= ctrl_ff[`CTRL_SLOPE_HI:`CTRL_SLOPE_LO];
			end else if (osc_tick_ff) begin
				per_cnt_ff <= per_cnt_ff + 8'h01;
			end
		end
	end

	// period pulse, enable and slope outputs
	assign pwm_period_start = start_ff;
	assign bridge_hiz = ~ctrl_ff[`CTRL_ENABLE];
	// code 00 is strongest drive, 11 the weakest
	assign gate_drive_strength = slope_act_ff;

	////////////////////////////////////////////////////////////////////////
	// per-coil regulation loop

	wire [NCOIL-1:0] neg;
	wire [NCOIL-1:0] rdson;
	wire [2*NCOIL-1:0] hs_req;
	wire [2*NCOIL-1:0] ls_req;

	genvar c;
	generate
		for (c = 0; c < NCOIL; c = c + 1) begin : g_coil
			reg [1:0] st_ff;
			reg neg_bit_ff;
			reg rdson_bit_ff;
			wire fwd;
			wire fast;
			wire slow;

			// forward until the comparator trips, then slow decay
			always @(posedge core_clk) begin
				if (srst || !ctrl_ff[`CTRL_ENABLE]) begin
					st_ff <= `ST_OFF;
					neg_bit_ff <= 1'b0;
				end else if (osc_tick_ff) begin
					if (per_end) begin
						neg_bit_ff <= coil_negative[c];
						// above target at period start means a step down
						st_ff <= coil_above[c] ? `ST_FAST : `ST_FWD;
					end else begin
						case (st_ff)
						`ST_OFF: st_ff <= `ST_OFF;
						// on time stretches past half period if needed
						`ST_FWD: st_ff <= coil_above[c] ? `ST_SLOW : `ST_FWD;
						`ST_FAST: st_ff <= coil_above[c] ? `ST_FAST : `ST_SLOW;
						`ST_SLOW: st_ff <= `ST_SLOW;
						default: st_ff <= `ST_OFF;
						endcase
					end
				end
			end

			// low-side resistance from range and micro-step level
			always @(posedge core_clk) begin
				if (srst) begin
					rdson_bit_ff <= 1'b0;
				end else begin
					rdson_bit_ff <= current_range_high |
						(coil_level[c*LVL_W +: LVL_W] >= RDSON_THR);
				end
			end

			// per-coil registers gathered into flat buses, one driver each
			assign coil_st[2*c +: 2] = st_ff;
			assign neg[c] = neg_bit_ff;
			assign rdson[c] = rdson_bit_ff;

			// map coil phase onto the two half-bridges a and b
			assign fwd = (st_ff == `ST_FWD);
			assign fast = (st_ff == `ST_FAST);
			assign slow = (st_ff == `ST_SLOW);
			assign hs_req[2*c] = (fwd & ~neg[c]) | (fast & neg[c]);
			assign ls_req[2*c] = (fwd & neg[c]) | (fast & ~neg[c]) | slow;
			assign hs_req[2*c+1] = (fwd & neg[c]) | (fast & ~neg[c]);
			assign ls_req[2*c+1] = (fwd & ~neg[c]) | (fast & neg[c]) | slow;
		end
	endgenerate

	assign ls_low_rdson = rdson;

	////////////////////////////////////////////////////////////////////////
	// half-bridge gate sequencers

	genvar h;
	generate
		for (h = 0; h < 2*NCOIL; h = h + 1) begin : g_half
			half_bridge_gate #(
				.DT_CYCLES(DT_CYCLES)
			) u_gate (
				.core_clk(core_clk),
				.srst(srst),
				.enable(ctrl_ff[`CTRL_ENABLE]),
				.hs_req(hs_req[h]),
				.ls_req(ls_req[h]),
				.fault_clear(fault_clear_ff),
				.hs_rev(hs_reverse[h]),
				.ls_rev(ls_reverse[h]),
				.hs_oc(hs_overcurrent[h]),
				.ls_oc(ls_overcurrent[h]),
				.hs_desat(hs_desat[h]),
				.ls_desat(ls_desat[h]),
				.hs_on(hs_gate[h]),
				.ls_on(ls_gate[h]),
				.hs_limit(hs_current_limit[h]),
				.ls_limit(ls_current_limit[h]),
				.hs_fault(hs_fault[h]),
				.ls_fault(ls_fault[h])
			);
		end
	endgenerate

endmodule // hbridge_pwm_current_regulator

/* File: sim/hbridge_checker.sv */
// port assertions for the dual h-bridge regulator
`timescale 1ns/1ps
module hbridge_checker #(
	parameter NCOIL = 2,
	parameter LVL_W = 7
) (
	// clock and reset
	input wire core_clk,
	input wire srst,
	// bus handshake
	input wire read,
	input wire write,
	input wire waitrequest,
	// requests and sense
	input wire [NCOIL*LVL_W-1:0] coil_level,
	input wire current_range_high,
	input wire [2*NCOIL-1:0] hs_overcurrent,
	input wire [2*NCOIL-1:0] hs_desat,
	// drive outputs
	input wire [2*NCOIL-1:0] hs_gate,
	input wire [2*NCOIL-1:0] ls_gate,
	input wire [2*NCOIL-1:0] hs_current_limit,
	input wire bridge_hiz,
	input wire [NCOIL-1:0] ls_low_rdson,
	input wire pwm_period_start
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	////////////////////////////////////////
	// drive rules
	chk_hiz_all_off: assert property (bridge_hiz |=> (hs_gate | ls_gate) == 0)
		else $error("gate on while bridges disabled");
	chk_no_overlap: assert property ((hs_gate & ls_gate) == 0)
		else $error("high and low switch on together");
	chk_dead_gap: assert property ($fell(ls_gate[0]) |-> !hs_gate[0] [*4])
		else $error("dead time too short");
	chk_limit_track: assert property (!$past(srst) |->
		hs_current_limit == $past(hs_gate & hs_overcurrent))
		else $error("current limit does not follow overcurrent");
	chk_desat_off: assert property (hs_gate[0] && hs_desat[0] |=> !hs_gate[0] [*8])
		else $error("switch kept on after excess voltage");
	chk_rdson_sel: assert property (!$past(srst) |->
		ls_low_rdson[0] == $past(current_range_high || coil_level[6:0] >= 7'h40))
		else $error("low-side resistance select wrong");
	////////////////////////////////////////
	// bus and period rules
	chk_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("more than one wait cycle");
	chk_idle_wait: assert property (!(read || write) |-> !waitrequest)
		else $error("wait raised without request");
	chk_period_pulse: assert property (pwm_period_start |=> !pwm_period_start [*8])
		else $error("period pulse too long or too close");
	cover property (pwm_period_start && !bridge_hiz);
	cover property (hs_gate[0] && hs_desat[0]);
	cover property (hs_current_limit != 0);
endmodule // hbridge_checker
bind hbridge_pwm_current_regulator hbridge_checker #(.NCOIL(NCOIL), .LVL_W(LVL_W))
	i_hbridge_checker (.core_clk, .srst, .read, .write, .waitrequest, .coil_level,
	.current_range_high, .hs_overcurrent, .hs_desat, .hs_gate, .ls_gate,
	.hs_current_limit, .bridge_hiz, .ls_low_rdson, .pwm_period_start);

/* File: sim/coil_model.sv */
// behavioural model of two motor coils feeding the comparators
`timescale 1ns/1ps
module coil_model (
	// clock
	input wire core_clk,
	// bridge gates and requested magnitudes
	input wire [3:0] hs_gate,
	input wire [3:0] ls_gate,
	input wire [13:0] coil_level,
	// comparator result per coil
	output reg [1:0] coil_above
);
	integer cur [0:1];
	integer c;
	integer tk = 0;
	initial begin
		cur[0] = 0;
		cur[1] = 0;
	end
	// drive raises current, reversed drive drops it fast, recirculation slowly
	always @(posedge core_clk) begin
		tk = tk + 1;
		for (c = 0; c < 2; c = c + 1) begin
			if (hs_gate[2*c] && ls_gate[2*c+1])
				cur[c] = cur[c] + 1;
			else if (hs_gate[2*c+1] && ls_gate[2*c])
				cur[c] = cur[c] - 1;
			else if (tk % 16 == 0)
				cur[c] = cur[c] - (cur[c] > 0) + (cur[c] < 0);
			coil_above[c] <= (cur[c] < 0 ? -cur[c] : cur[c]) >= coil_level[7*c+:7];
		end
	end
endmodule // coil_model

/* File: sim/hbridge_pwm_current_regulator_tb_top.sv */
// self-checking bench for the dual h-bridge regulator
`timescale 1ns/1ps
module hbridge_pwm_current_regulator_tb_top;
	reg core_clk = 0;
	reg srst = 1;
	reg [3:0] address = 4'h0;
	reg read = 0;
	reg write = 0;
	reg [3:0] byteenable = 4'hF;
	reg [31:0] writedata = 32'h0;
	reg [1:0] coil_negative = 2'h2;
	reg [13:0] coil_level = 14'h0;
	reg current_range_high = 0;
	reg [3:0] hs_reverse = 4'h0;
	reg [3:0] hs_overcurrent = 4'h0;
	reg [3:0] hs_desat = 4'h0;
	reg [31:0] rd;
	wire [31:0] readdata;
	wire waitrequest, bridge_hiz, pwm_period_start;
	wire [3:0] hs_gate, ls_gate, hs_current_limit;
	wire [1:0] coil_above, gate_drive_strength, ls_low_rdson;
	integer n_fail = 0, cmp_count = 0, cyc = 0, fast = 0, ctrl_m, i, p, f0;
	always #50 core_clk = ~core_clk;
	hbridge_pwm_current_regulator i_hbridge_pwm_current_regulator (.core_clk, .srst,
		.address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest,
		.coil_above, .coil_negative, .coil_level, .current_range_high, .hs_reverse,
		.ls_reverse(4'h0), .hs_overcurrent, .ls_overcurrent(4'h0), .hs_desat,
		.ls_desat(4'h0), .hs_gate, .ls_gate, .hs_current_limit, .ls_current_limit(),
		.bridge_hiz, .gate_drive_strength, .ls_low_rdson, .pwm_period_start);
	coil_model i_coil_model (.core_clk, .hs_gate, .ls_gate, .coil_level, .coil_above);
	////////////////////////////////////////
	// timeout and reversed-drive cycle count on coil 0
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		fast <= fast + (hs_gate[1] && ls_gate[0]);
		if (cyc == 30000) begin
			n_fail = n_fail + 1;
			final_report;
		end
	end
	task check(input [31:0] seen, input [31:0] exp, input [8*8:1] what);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("CHECK FAILED %0s exp %0h seen %0h", what, exp, seen);
			end
		end
	endtask
	task bus(input wr, input [3:0] a, input [31:0] d);
		begin
			@(posedge core_clk);
			address <= a;
			read <= !wr;
			write <= wr;
			writedata <= d;
			@(posedge core_clk);
			while (waitrequest !== 1'b0) @(posedge core_clk);
			rd = readdata;
			read <= 0;
			write <= 0;
		end
	endtask
	task wait_period;
		begin
			@(posedge core_clk);
			while (pwm_period_start !== 1'b1) @(posedge core_clk);
		end
	endtask
	// one period length against a tick range at 2.5 core cycles a tick
	task period_check(input integer t0, input integer t1);
		begin
			wait_period;
			wait_period;
			p = 1;
			@(posedge core_clk);
			while (pwm_period_start !== 1'b1) begin
				@(posedge core_clk);
				p = p + 1;
			end
			check(p >= t0 * 5 / 2 && p <= t1 * 5 / 2 + 1, 1, "period");
		end
	endtask
	task final_report;
		begin
			$display("compares %0d mismatches %0d", cmp_count, n_fail);
			if (n_fail == 0 && cmp_count > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	////////////////////////////////////////
	// main sequence
	initial begin
		i = $urandom(20);
		repeat (12) @(posedge core_clk);
		srst <= 0;
		check(bridge_hiz, 1, "hiz");
		bus(0, 4'h0, 0);
		check(rd, 0, "ctrl");
		bus(0, 4'hC, 0);
		check(rd, 0, "unmapped");
		byteenable <= 4'h0;
		bus(1, 4'h0, 32'h1);
		byteenable <= 4'hF;
		bus(0, 4'h0, 0);
		check(rd, 0, "be");
		$display("registers done");
		coil_level <= {7'h50, 7'h50};
		for (i = 0; i < 4; i = i + 1) begin
			ctrl_m = (i << 3) | 1;
			bus(1, 4'h0, ctrl_m | ($urandom & 32'hFFFFFFE0));
			bus(0, 4'h0, 0);
			check(rd, ctrl_m, "ctrl");
			wait_period;
			@(posedge core_clk);
			check(gate_drive_strength, i, "slope");
		end
		$display("slopes done");
		f0 = fast;
		period_check(175, 175);
		check(fast - f0, 0, "steady");
		f0 = fast;
		coil_level[6:0] <= 7'h10;
		wait_period;
		wait_period;
		check(fast > f0, 1, "fastdec");
		$display("decay done");
		bus(1, 4'h0, 32'h3);
		period_check(87, 87);
		bus(0, 4'h4, 0);
		check(rd[13], 1, "double");
		bus(1, 4'h0, 32'h5);
		for (i = 0; i < 3; i = i + 1)
			period_check(171, 178);
		bus(0, 4'h4, 0);
		check(rd[16], 1, "jitter");
		$display("periods done");
		hs_reverse[1] <= 1;
		for (i = 0; i < 40; i = i + 1) @(posedge core_clk) p = i == 0 ? 0 : p + hs_gate[1];
		hs_reverse[1] <= 0;
		check(p > 0, 1, "reverse");
		hs_desat[0] <= 1;
		hs_overcurrent[0] <= 1;
		@(posedge core_clk);
		while (hs_gate[0] !== 1'b1) @(posedge core_clk);
		hs_desat[0] <= 0;
		hs_overcurrent[0] <= 0;
		@(posedge core_clk);
		check(hs_current_limit[0], 1, "limit");
		bus(0, 4'h4, 0);
		check(rd[0], 1, "fault");
		bus(1, 4'h8, 32'h1);
		bus(0, 4'h4, 0);
		check(rd[0], 0, "clear");
		$display("protection done");
		for (i = 0; i < 6; i = i + 1) begin
			current_range_high <= $urandom;
			coil_level[6:0] <= $urandom;
			repeat (2) @(posedge core_clk);
			check(ls_low_rdson[0], current_range_high | (coil_level[6:0] >= 7'h40), "rdson");
		end
		bus(1, 4'h0, 32'h0);
		repeat (2) @(posedge core_clk);
		check(hs_gate | ls_gate | !bridge_hiz, 0, "off");
		$display("disable done");
		final_report;
	end
endmodule // hbridge_pwm_current_regulator_tb_top
